// ==== design/ssf_pkg.sv ====
// Constants, register map and helpers for the serial status-flag block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package ssf_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FLAG_W = 10;
  localparam int unsigned WORD_W = 9;
  localparam int unsigned DIV_W = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_DATA = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_BAUD = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_CTRL_ONE = 8'h0c;
  localparam logic [ADDR_W-1:0] ADR_CTRL_TWO = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_CTRL_THREE = 8'h14;
  localparam logic [ADDR_W-1:0] ADR_GUARD = 8'h18;
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = 8'h1c;
  localparam logic [ADDR_W-1:0] ADR_IRQ_EVENT = 8'h20;

  // Status bit positions
  localparam int unsigned BIT_CTS = 9;
  localparam int unsigned BIT_BRK = 8;
  localparam int unsigned BIT_TBE = 7;
  localparam int unsigned BIT_TXC = 6;
  localparam int unsigned BIT_RXF = 5;
  localparam int unsigned BIT_IDLE = 4;
  localparam int unsigned BIT_ORE = 3;
  localparam int unsigned BIT_NE = 2;
  localparam int unsigned BIT_FE = 1;
  localparam int unsigned BIT_PE = 0;

  localparam logic [FLAG_W-1:0] STATUS_RESET = 10'h0c0;
  localparam logic [FLAG_W-1:0] W0C_MASK = 10'h360;
  localparam logic [FLAG_W-1:0] SEQ_RD_MASK = 10'h01f;
  localparam logic [FLAG_W-1:0] SEQ_WR_MASK = 10'h040;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  // Merge new data into old under byte enables
  function automatic logic [DATA_W-1:0] ssf_apply_sel(input logic [DATA_W-1:0] old_v,
                                                      input logic [DATA_W-1:0] new_v,
                                                      input logic [3:0] sel);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : ssf_apply_sel

endpackage : ssf_pkg

// ==== design/ssf_reg_if.sv ====
// Register access strobes between the bus slave and the flag core.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface ssf_reg_if;
  import ssf_pkg::*;
  logic rd_stb;
  logic wr_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [3:0] sel;
  logic [DATA_W-1:0] rdata;
  modport slave (output rd_stb, output wr_stb, output addr, output wdata, output sel,
                 input rdata);
  modport core (input rd_stb, input wr_stb, input addr, input wdata, input sel,
                output rdata);
endinterface : ssf_reg_if

// ==== design/ssf_sync.sv ====
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/100ps
module ssf_sync (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic async_i,
  output logic sync_o
);
  import ssf_pkg::*;

  logic stage_one;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      stage_one <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end
endmodule : ssf_sync

// ==== design/ssf_wb_slave.sv ====
// Classic Wishbone slave front end: one wait state, registered read data.
// Assumes a single-cycle master that holds its request until ack.
`timescale 1ns/100ps
module ssf_wb_slave (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ssf_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ssf_pkg::DATA_W-1:0] wb_dat_i,
  output logic [ssf_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  ssf_reg_if.slave bus
);
  import ssf_pkg::*;

  wire req = wb_cyc_i & wb_stb_i;
  wire first = req & ~wb_ack_o;

  // Side effects land on the edge where the master samples ack
  assign bus.rd_stb = req & wb_ack_o & ~wb_we_i;
  assign bus.wr_stb = req & wb_ack_o & wb_we_i;
  assign bus.addr = wb_adr_i;
  assign bus.wdata = wb_dat_i;
  assign bus.sel = wb_sel_i;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= WORD_ZERO;
    end
    else
    begin
      wb_ack_o <= first;
      wb_dat_o <= first ? bus.rdata : wb_dat_o;
    end
  end

  a_ack_single: assert property (@(posedge clk_i) disable iff (srst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
endmodule : ssf_wb_slave

// ==== design/ssf_serial_status.sv ====
// Status flags and register map of a serial transceiver.
// Assumes receiver and transmitter engines on clk_i give one-cycle event pulses;
// the clear-to-send pin is asynchronous.
// Operation
// - A level change on clear-to-send sets status bit 9, cleared only by writing zero to it.
// - A detected break frame sets status bit 8, cleared by writing zero to it.
// - Read-only bit 7 resets to one, sets when the buffer moves to the shifter, clears on data write.
// - Bit 6 resets to one, sets at end of transmission, clears by status read then data write or zero.
// - Bit 5 sets when a word enters the data register, clears on data read or written zero.
// - Read-only bit 4 sets on idle line, cleared by a status read followed by a data read.
// - Read-only bit 3 sets when a word completes while bit 5 is set, cleared by status then data read; not set here if a data read falls in that cycle.
// - During overrun the held word stays and later words are dropped.
// - Read-only bit 2 sets on noise in a frame, cleared by status then data read.
// - Read-only bit 1 sets on low stop bit, heavy noise or break, cleared by status then data read.
// - Read-only bit 0 sets on parity failure, cleared by status then data read.
// - Status bits 31 to 10 always read zero.
// - Seven word registers sit at 0x00 to 0x18; status resets to 0xc0 and others to zero.
// - The interrupt is high while any flag is set together with its enable bit.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
module ssf_serial_status (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ssf_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ssf_pkg::DATA_W-1:0] wb_dat_i,
  output logic [ssf_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cts_i,
  input wire logic tx_load_i,
  input wire logic tx_done_i,
  input wire logic rx_valid_i,
  input wire logic [ssf_pkg::WORD_W-1:0] rx_word_i,
  input wire logic rx_noise_i,
  input wire logic rx_frame_err_i,
  input wire logic rx_parity_err_i,
  input wire logic rx_break_i,
  input wire logic rx_idle_i,
  output logic [ssf_pkg::WORD_W-1:0] tx_data_o,
  output logic tx_buffer_empty_o,
  output logic [ssf_pkg::DIV_W-1:0] baud_div_o,
  output logic [ssf_pkg::DATA_W-1:0] ctrl_one_o,
  output logic [ssf_pkg::DATA_W-1:0] ctrl_two_o,
  output logic [ssf_pkg::DATA_W-1:0] ctrl_three_o,
  output logic [ssf_pkg::DATA_W-1:0] guard_time_o,
  output logic irq_o
);
  import ssf_pkg::*;

  ssf_reg_if bus ();

  ssf_wb_slave u_slave (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .bus(bus)
  );

  logic cts_sync;

  ssf_sync u_cts_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i(cts_i),
    .sync_o(cts_sync)
  );

  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] seq_pend;
  logic [FLAG_W-1:0] irq_mask;
  logic [FLAG_W-1:0] irq_event;
  logic [WORD_W-1:0] rx_data;
  logic cts_prev;
  logic cts_seen;

  // Address decode
  wire hit_status = bus.addr == ADR_STATUS;
  wire hit_data = bus.addr == ADR_DATA;
  wire hit_baud = bus.addr == ADR_BAUD;
  wire hit_one = bus.addr == ADR_CTRL_ONE;
  wire hit_two = bus.addr == ADR_CTRL_TWO;
  wire hit_three = bus.addr == ADR_CTRL_THREE;
  wire hit_guard = bus.addr == ADR_GUARD;
  wire hit_mask = bus.addr == ADR_IRQ_MASK;
  wire hit_event = bus.addr == ADR_IRQ_EVENT;

  wire sts_rd = bus.rd_stb & hit_status;
  wire sts_wr = bus.wr_stb & hit_status;
  wire data_rd = bus.rd_stb & hit_data;
  wire data_wr = bus.wr_stb & hit_data;

  wire [DATA_W-1:0] lane_mask = {{8{bus.sel[3]}}, {8{bus.sel[2]}},
                                 {8{bus.sel[1]}}, {8{bus.sel[0]}}};
  wire [FLAG_W-1:0] wr_bits = bus.wdata[FLAG_W-1:0];
  wire [FLAG_W-1:0] wr_lanes = lane_mask[FLAG_W-1:0];

  // Change seen only once the synchronised level has been sampled after reset
  wire cts_change = cts_seen & (cts_sync != cts_prev);
  // overrun when a word lands on a full buffer that is not being read
  wire overrun = rx_valid_i & flags[BIT_RXF] & ~data_rd;

  // Hardware set terms
  wire [FLAG_W-1:0] set_vec;
  assign set_vec[BIT_CTS] = cts_change;
  assign set_vec[BIT_BRK] = rx_break_i;
  assign set_vec[BIT_TBE] = tx_load_i;
  assign set_vec[BIT_TXC] = tx_done_i;
  assign set_vec[BIT_RXF] = rx_valid_i;
  assign set_vec[BIT_IDLE] = rx_idle_i;
  assign set_vec[BIT_ORE] = overrun;
  assign set_vec[BIT_NE] = rx_valid_i & rx_noise_i;
  assign set_vec[BIT_FE] = (rx_valid_i & rx_frame_err_i) | rx_break_i;
  assign set_vec[BIT_PE] = rx_valid_i & rx_parity_err_i;

  // only zeros in enabled lanes clear write-zero flags
  wire [FLAG_W-1:0] w0c_clr = {FLAG_W{sts_wr}} & wr_lanes & ~wr_bits & W0C_MASK;
  // sequence clears only what a prior status read armed
  wire [FLAG_W-1:0] seq_clr = ({FLAG_W{data_rd}} & seq_pend & SEQ_RD_MASK) |
                              ({FLAG_W{data_wr}} & seq_pend & SEQ_WR_MASK);
  wire [FLAG_W-1:0] clr_vec;
  assign clr_vec[BIT_TBE] = data_wr;
  assign clr_vec[BIT_RXF] = data_rd | w0c_clr[BIT_RXF];
  assign clr_vec[BIT_CTS] = w0c_clr[BIT_CTS];
  assign clr_vec[BIT_BRK] = w0c_clr[BIT_BRK];
  assign clr_vec[BIT_TXC] = w0c_clr[BIT_TXC] | seq_clr[BIT_TXC];
  assign clr_vec[BIT_IDLE:BIT_PE] = seq_clr[BIT_IDLE:BIT_PE];

  // Set wins over clear
  wire [FLAG_W-1:0] next_flags = (flags & ~clr_vec) | set_vec;
  wire [FLAG_W-1:0] next_seq_pend = sts_rd ? (flags & (SEQ_RD_MASK | SEQ_WR_MASK)) :
                                    (seq_pend & ~seq_clr);
  wire evt_w1c = bus.wr_stb & hit_event;
  wire [FLAG_W-1:0] next_irq_event = (irq_event & ~({FLAG_W{evt_w1c}} & wr_lanes & wr_bits))
                                     | set_vec;
  // hold the buffered word while it is unread
  wire rx_load = rx_valid_i & ~overrun;

  wire [DATA_W-1:0] status_word = {{(DATA_W-FLAG_W){1'b0}}, flags};
  wire [DATA_W-1:0] rd_word =
    hit_status ? status_word :
    hit_data ? {{(DATA_W-WORD_W){1'b0}}, rx_data} :
    hit_baud ? {{(DATA_W-DIV_W){1'b0}}, baud_div_o} :
    hit_one ? ctrl_one_o :
    hit_two ? ctrl_two_o :
    hit_three ? ctrl_three_o :
    hit_guard ? guard_time_o :
    hit_mask ? {{(DATA_W-FLAG_W){1'b0}}, irq_mask} :
    hit_event ? {{(DATA_W-FLAG_W){1'b0}}, irq_event} : WORD_ZERO;
  assign bus.rdata = rd_word;

  wire [DATA_W-1:0] merged_baud = ssf_apply_sel({{(DATA_W-DIV_W){1'b0}}, baud_div_o},
                                                bus.wdata, bus.sel);
  wire [DATA_W-1:0] merged_data = ssf_apply_sel({{(DATA_W-WORD_W){1'b0}}, tx_data_o},
                                                bus.wdata, bus.sel);
  wire [DATA_W-1:0] merged_mask = ssf_apply_sel({{(DATA_W-FLAG_W){1'b0}}, irq_mask},
                                                bus.wdata, bus.sel);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      flags <= STATUS_RESET;
      seq_pend <= '0;
      irq_event <= '0;
      irq_mask <= '0;
      rx_data <= '0;
      tx_data_o <= '0;
      baud_div_o <= '0;
      ctrl_one_o <= WORD_ZERO;
      ctrl_two_o <= WORD_ZERO;
      ctrl_three_o <= WORD_ZERO;
      guard_time_o <= WORD_ZERO;
      cts_prev <= 1'b0;
      cts_seen <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      seq_pend <= next_seq_pend;
      irq_event <= next_irq_event;
      cts_prev <= cts_sync;
      cts_seen <= 1'b1;
      rx_data <= rx_load ? rx_word_i : rx_data;
      tx_data_o <= data_wr ? merged_data[WORD_W-1:0] : tx_data_o;
      baud_div_o <= (bus.wr_stb & hit_baud) ? merged_baud[DIV_W-1:0] : baud_div_o;
      irq_mask <= (bus.wr_stb & hit_mask) ? merged_mask[FLAG_W-1:0] : irq_mask;
      if (bus.wr_stb & hit_one)
      begin
        ctrl_one_o <= ssf_apply_sel(ctrl_one_o, bus.wdata, bus.sel);
      end
      if (bus.wr_stb & hit_two)
      begin
        ctrl_two_o <= ssf_apply_sel(ctrl_two_o, bus.wdata, bus.sel);
      end
      if (bus.wr_stb & hit_three)
      begin
        ctrl_three_o <= ssf_apply_sel(ctrl_three_o, bus.wdata, bus.sel);
      end
      if (bus.wr_stb & hit_guard)
      begin
        guard_time_o <= ssf_apply_sel(guard_time_o, bus.wdata, bus.sel);
      end
    end
  end

  assign tx_buffer_empty_o = flags[BIT_TBE];
  // level interrupt from enabled flags or latched events
  assign irq_o = |((flags | irq_event) & irq_mask);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_cts_change_sets: assert property (cts_change |=> flags[BIT_CTS])
    else $error("cts change did not set flag");
  a_break_sets_both: assert property (rx_break_i |=> flags[BIT_BRK] && flags[BIT_FE])
    else $error("break did not set break and framing flags");
  a_tbe_write_clears: assert property (data_wr && !tx_load_i |=> !tx_buffer_empty_o)
    else $error("data write did not clear buffer empty");
  a_txc_seq_clear: assert property (seq_pend[BIT_TXC] && data_wr && !tx_done_i
    |=> !flags[BIT_TXC])
    else $error("status read then data write left complete flag");
  a_rxf_load_word: assert property (rx_valid_i && !flags[BIT_RXF]
    |=> flags[BIT_RXF] && rx_data == $past(rx_word_i))
    else $error("received word not loaded");

  a_cts_zero_clear: assert property (w0c_clr[BIT_CTS] && !cts_change
    |=> !flags[BIT_CTS])
    else $error("zero write left change flag");
  a_brk_zero_clear: assert property (w0c_clr[BIT_BRK] && !rx_break_i
    |=> !flags[BIT_BRK])
    else $error("zero write left break flag");
  a_tbe_load_sets: assert property (tx_load_i |=> tx_buffer_empty_o)
    else $error("buffer move did not set empty flag");
  a_txc_end_sets: assert property (tx_done_i |=> flags[BIT_TXC])
    else $error("end of transmission not flagged");
  a_txc_zero_clear: assert property (w0c_clr[BIT_TXC] && !tx_done_i
    |=> !flags[BIT_TXC])
    else $error("zero write left complete flag");
  a_rxf_read_clear: assert property (data_rd && !rx_valid_i |=> !flags[BIT_RXF])
    else $error("data read left buffer full flag");
  a_idle_seq_clear: assert property (data_rd && seq_pend[BIT_IDLE] && !rx_idle_i
    |=> !flags[BIT_IDLE])
    else $error("read sequence left idle flag");
  a_overrun_clear: assert property (data_rd && seq_pend[BIT_ORE]
    |=> !flags[BIT_ORE])
    else $error("read sequence left overrun flag");
  a_noise_sets: assert property (rx_valid_i && rx_noise_i |=> flags[BIT_NE])
    else $error("noise not flagged");
  a_frame_sets: assert property (rx_valid_i && rx_frame_err_i |=> flags[BIT_FE])
    else $error("framing error not flagged");
  a_parity_clear: assert property (data_rd && seq_pend[BIT_PE]
    && !(rx_valid_i && rx_parity_err_i) |=> !flags[BIT_PE])
    else $error("read sequence left parity flag");
  a_status_upper_zero: assert property (hit_status
    |-> bus.rdata[DATA_W-1:FLAG_W] == '0)
    else $error("status read word has upper bits set");
  a_unmapped_zero: assert property (!(hit_status || hit_data || hit_baud || hit_one
    || hit_two || hit_three || hit_guard || hit_mask || hit_event)
    |-> bus.rdata == WORD_ZERO)
    else $error("unmapped address read nonzero");
  a_irq_quiet: assert property (irq_mask == '0 |-> !irq_o)
    else $error("interrupt with all enables off");
  a_w1_keeps_txc: assert property (sts_wr && bus.sel[0] && bus.wdata[BIT_TXC]
    && flags[BIT_TXC] |=> flags[BIT_TXC])
    else $error("writing one cleared complete flag");

  a_idle_sets: assert property (rx_idle_i |=> flags[BIT_IDLE])
    else $error("idle line did not set flag");
  a_overrun_keeps: assert property (rx_valid_i && flags[BIT_RXF] && !data_rd
    |=> flags[BIT_ORE] && $stable(rx_data))
    else $error("overrun replaced buffered word");
  a_parity_sets: assert property (rx_valid_i && rx_parity_err_i |=> flags[BIT_PE])
    else $error("parity error not flagged");
  a_reserved_zero: assert property (bus.rd_stb == 1'b0 ##0 !wb_ack_o && wb_cyc_i
    && wb_stb_i && hit_status |=> wb_dat_o[DATA_W-1:FLAG_W] == '0)
    else $error("reserved status bits not zero");
  a_reset_status: assert property ($fell(srst_i) |-> flags == STATUS_RESET
    && baud_div_o == '0 && ctrl_one_o == WORD_ZERO)
    else $error("wrong reset values");
  a_irq_level: assert property (((flags & irq_mask) != '0) |-> irq_o)
    else $error("enabled flag without interrupt");
  a_w1_keeps_flag: assert property (sts_wr && bus.sel[1] && bus.wdata[BIT_CTS]
    && flags[BIT_CTS] |=> flags[BIT_CTS])
    else $error("writing one cleared a flag");
  a_unarmed_err_kept: assert property (data_rd && !seq_pend[BIT_PE] && flags[BIT_PE]
    |=> flags[BIT_PE])
    else $error("error cleared without prior status read");

  c_overrun: cover property (overrun);
  c_err_cleared: cover property (sts_rd && flags[BIT_FE] ##[1:8] data_rd);
  c_txc_by_zero: cover property (w0c_clr[BIT_TXC]);
  c_irq_raised: cover property ($rose(irq_o));
  c_break_seen: cover property (rx_break_i);
endmodule : ssf_serial_status

// ==== testbench/ssf_far_end.sv ====
// Far-side model: turns bench commands into engine event pulses and the clear-to-send level.
// Assumes one clock shared with the block; a command pulse on fire_i lasts one cycle.
`timescale 1ns/100ps
module ssf_far_end (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic fire_i,
  input wire logic [3:0] code_i,
  input wire logic [8:0] word_i,
  output logic cts_o,
  output logic tx_load_o,
  output logic tx_done_o,
  output logic rx_valid_o,
  output logic [8:0] rx_word_o,
  output logic rx_noise_o,
  output logic rx_frame_err_o,
  output logic rx_parity_err_o,
  output logic rx_break_o,
  output logic rx_idle_o
);
  logic rx_go;
  assign rx_go = fire_i && code_i >= 4'h3 && code_i <= 4'h6;
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cts_o <= 1'b0;
    end
    else if (fire_i && code_i == 4'h0)
    begin
      cts_o <= ~cts_o;
    end
    tx_load_o <= fire_i && code_i == 4'h1;
    tx_done_o <= fire_i && code_i == 4'h2;
    rx_valid_o <= rx_go;
    // Word line is not held between frames
    rx_word_o <= rx_go ? word_i : ~rx_word_o;
    rx_noise_o <= fire_i && code_i == 4'h4;
    rx_frame_err_o <= fire_i && code_i == 4'h5;
    rx_parity_err_o <= fire_i && code_i == 4'h6;
    rx_break_o <= fire_i && code_i == 4'h7;
    rx_idle_o <= fire_i && code_i == 4'h8;
  end
endmodule : ssf_far_end

// ==== testbench/test_ssf_serial_status.sv ====
// Self-checking bench for the serial status-flag block.
// Assumes the far-side model drives all engine inputs; read results checked by a monitor.
`timescale 1ns/100ps
module test_ssf_serial_status;
  import ssf_pkg::*;
  logic clk_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i, fire, cts, tl, td, rv, rn, rf, rp, rb, ri;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i, code;
  logic [DATA_W-1:0] wb_dat_i, wb_dat_o, rnd;
  logic wb_ack_o, irq_o, tbe;
  logic [8:0] word, rw, txd, w1, w2;
  logic [DATA_W-1:0] exp_q[$];
  int miscompares, check_count;
  ssf_serial_status dut (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cts_i(cts),
    .tx_load_i(tl), .tx_done_i(td), .rx_valid_i(rv), .rx_word_i(rw), .rx_noise_i(rn),
    .rx_frame_err_i(rf), .rx_parity_err_i(rp), .rx_break_i(rb), .rx_idle_i(ri),
    .tx_data_o(txd), .tx_buffer_empty_o(tbe), .baud_div_o(), .ctrl_one_o(),
    .ctrl_two_o(), .ctrl_three_o(), .guard_time_o(), .irq_o(irq_o));
  ssf_far_end far (.clk_i(clk_i), .srst_i(srst_i), .fire_i(fire), .code_i(code),
    .word_i(word), .cts_o(cts), .tx_load_o(tl), .tx_done_o(td), .rx_valid_o(rv),
    .rx_word_o(rw), .rx_noise_o(rn), .rx_frame_err_o(rf), .rx_parity_err_o(rp),
    .rx_break_o(rb), .rx_idle_o(ri));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  task automatic ev(input logic [3:0] c, input logic [8:0] w);
    @(posedge clk_i);
    code <= c;
    word <= w;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : ev
  task automatic chk_irq(input logic e);
    @(negedge clk_i);
    check({31'h0, irq_o}, {31'h0, e});
  endtask : chk_irq
  // Read results are taken off the queue as each read is acknowledged
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0)
      check(wb_dat_o, exp_q.pop_front());
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    conclude();
  end
  initial
  begin
    {srst_i, wb_cyc_i, wb_stb_i, wb_we_i, fire} = 5'h10;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    code = 4'h0;
    word = 9'h000;
    rnd = 32'h7008;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int a = 0; a <= 36; a += 4)
      rd(8'(a), a == 0 ? 32'hc0 : 32'h0);
    $display("test reset done");
    for (int a = 8; a <= 24; a += 4)
    begin
      rnd = lfsr(rnd);
      wb(1'b1, 8'(a), rnd);
      rd(8'(a), a == 8 ? {16'h0, rnd[15:0]} : rnd);
    end
    wb(1'b1, 8'h24, 32'hffff_ffff);
    rd(8'h24, 32'h0);
    wb(1'b1, 8'h00, 32'hffff_ffff);
    rd(8'h00, 32'hc0);
    $display("test map done");
    rnd = lfsr(rnd);
    wb(1'b1, 8'h04, rnd);
    rd(8'h00, 32'h00);
    wb(1'b1, 8'h04, rnd);
    @(negedge clk_i);
    check({23'h0, txd}, {23'h0, rnd[8:0]});
    check({31'h0, tbe}, 32'h0);
    rd(8'h00, 32'h00);
    ev(4'h1, 9'h0);
    rd(8'h00, 32'h80);
    ev(4'h2, 9'h0);
    rd(8'h00, 32'hc0);
    wb(1'b1, 8'h00, 32'h0);
    rd(8'h00, 32'h80);
    $display("test transmit done");
    rnd = lfsr(rnd);
    w1 = rnd[8:0];
    w2 = rnd[17:9];
    ev(4'h3, w1);
    rd(8'h00, 32'ha0);
    rd(8'h04, {23'h0, w1});
    rd(8'h00, 32'h80);
    ev(4'h3, w2);
    wb(1'b1, 8'h00, 32'h0);
    rd(8'h00, 32'h80);
    ev(4'h3, w1);
    ev(4'h3, w2);
    rd(8'h00, 32'ha8);
    rd(8'h04, {23'h0, w1});
    rd(8'h00, 32'h80);
    rd(8'h04, {23'h0, w1});
    rd(8'h00, 32'h80);
    $display("test receive done");
    ev(4'h4, w2);
    rd(8'h04, {23'h0, w2});
    rd(8'h00, 32'h84);
    ev(4'h6, w1);
    rd(8'h04, {23'h0, w1});
    rd(8'h00, 32'h81);
    rd(8'h04, {23'h0, w1});
    rd(8'h00, 32'h80);
    ev(4'h5, w2);
    rd(8'h00, 32'ha2);
    rd(8'h04, {23'h0, w2});
    rd(8'h00, 32'h80);
    ev(4'h7, w1);
    rd(8'h00, 32'h182);
    rd(8'h04, {23'h0, w2});
    wb(1'b1, 8'h00, 32'hffff_feff);
    rd(8'h00, 32'h80);
    ev(4'h8, w1);
    rd(8'h04, {23'h0, w2});
    rd(8'h00, 32'h90);
    rd(8'h04, {23'h0, w2});
    rd(8'h00, 32'h80);
    $display("test errors done");
    ev(4'h0, w1);
    rd(8'h00, 32'h280);
    wb(1'b1, 8'h00, 32'h200);
    rd(8'h00, 32'h280);
    wb(1'b1, 8'h00, 32'h0);
    rd(8'h00, 32'h80);
    wb(1'b1, 8'h20, 32'h3ff);
    wb(1'b1, 8'h1c, 32'h200);
    chk_irq(1'b0);
    ev(4'h0, w1);
    chk_irq(1'b1);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h20, 32'h200);
    chk_irq(1'b0);
    wb(1'b1, 8'h1c, 32'h080);
    chk_irq(1'b1);
    $display("test interrupt done");
    repeat (2) @(posedge clk_i);
    conclude();
  end
endmodule : test_ssf_serial_status
